// ===== verilog/fogc_pkg.sv
`default_nettype none
package fogc_pkg;
  // ****************************************
  // pin function selection codes
  // ****************************************
  localparam logic [2:0] SEL_FAIL0 = 3'h0;
  localparam logic [2:0] SEL_FAIL2 = 3'h2;
  localparam logic [2:0] SEL_OFF = 3'h4;
  localparam logic [2:0] SEL_WAKE = 3'h5;
  localparam logic [2:0] SEL_LS = 3'h6;
  localparam logic [2:0] SEL_HS = 3'h7;
  localparam logic [2:0] SEL_RESET = 3'h0;
  // ****************************************
  // operating mode codes, binary as driven by the mode controller
  // ****************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h2;
  localparam logic [2:0] MODE_RESTART = 3'h3;
  localparam logic [2:0] MODE_FAILSAFE = 3'h4;
  localparam logic [2:0] MODE_INIT = 3'h5;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int BLANK_US = 10;
  localparam int BLANK_CYC = (BLANK_US * CLK_HZ + 999999) / 1000000;
  localparam int FILT_US = 13;
  localparam int FILT_CYC = (FILT_US * CLK_HZ + 999999) / 1000000;
  localparam int CNT_W = 9;
  // pwm duty full scale
  localparam int PWM_W = 8;
  localparam logic [7:0] PWM_FULL = 8'hff;
endpackage
`default_nettype wire

// ===== verilog/fogc_wake_filter.sv
`timescale 1ns/1ps
`default_nettype none
// blanking then filter of the wake input level
module fogc_wake_filter
#(
  parameter int BLANK = fogc_pkg::BLANK_CYC,
  parameter int FILT = fogc_pkg::FILT_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire logic pinLevel,
  // result
  output logic filtLevel,
  output logic edgeSeen
);
  typedef struct packed
  {
    logic [fogc_pkg::CNT_W-1:0] cnt;
    logic blanked;
    logic level;
    logic edgeP;
  } fogc_wf_s;
  fogc_wf_s st, next_st;
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.edgeP = 1'b0;
    if (!enable)
    begin
      // reference kept, blanking restarts on next selection
      next_st.cnt = '0;
      next_st.blanked = 1'b0;
    end
    else if (!st.blanked)
    begin
      // blanking interval before level counts
      if (st.cnt == fogc_pkg::CNT_W'(BLANK - 1))
      begin
        next_st.blanked = 1'b1;
        next_st.cnt = '0;
      end
      else
        next_st.cnt = st.cnt + 1'b1;
    end
    else if (pinLevel != st.level)
    begin
      // filter runs only after blanking
      if (st.cnt == fogc_pkg::CNT_W'(FILT - 1))
      begin
        next_st.level = pinLevel;
        next_st.edgeP = 1'b1;
        next_st.cnt = '0;
      end
      else
        next_st.cnt = st.cnt + 1'b1;
    end
    else
      next_st.cnt = '0;
  end
  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end
  assign filtLevel = st.level;
  assign edgeSeen = st.edgeP;
  // no edge may be qualified in the cycle the enable rises or the one after it
  a_blank_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(enable) |-> !edgeSeen [*2]) else $error("edge during blanking");
endmodule
`default_nettype wire

// ===== verilog/fogc_pwm.sv
`timescale 1ns/1ps
`default_nettype none
// simple pwm generator for the switch roles
module fogc_pwm
#(
  parameter int W = fogc_pkg::PWM_W
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // settings
  input wire logic [W-1:0] duty,
  input wire logic [W-1:0] freqDiv,
  // output
  output logic onPhase
);
  typedef struct packed
  {
    logic [W-1:0] pre;
    logic [W-1:0] phase;
    logic on;
  } fogc_pwm_s;
  fogc_pwm_s st, next_st;
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    if (st.pre >= freqDiv)
    begin
      next_st.pre = '0;
      next_st.phase = st.phase + 1'b1;
    end
    else
      next_st.pre = st.pre + 1'b1;
    // 0 is always off, full scale always on
    if (duty == '0)
      next_st.on = 1'b0;
    else if (duty == W'(fogc_pkg::PWM_FULL))
      next_st.on = 1'b1;
    else
      next_st.on = (next_st.phase < duty);
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end
  assign onPhase = st.on;
  a_zero_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (duty == '0) [*2] |-> !onPhase) else $error("pwm on at zero duty");
endmodule
`default_nettype wire

// ===== verilog/fogc_fail_output_and_gpio_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - pin starts as open-drain fail output
// - watchdog failure asserts, config-dependent count
// - thermal, short, gated overvoltage assert output
// - assertion sets failure flag, enters fail-safe except watchdog cause in config 3/4
// - asserted output stays low all modes
// - release only Normal, clean, flag cleared
// - watchdog cause also needs successful trigger
// - watchdog flag cleared on sleep entry, stop with watchdog disabled
// - test bit asserts, clears without trigger
// - test-only assertion released at restart
// - test bit drives pin only in fail role
// - decode three-bit pin function selection
// - selection changes in Normal, lockable
// - blanking interval before wake filter
// - wake capable, event flag, failsafe clear
// - selectable pull-up or pull-down
// - wake level status reporting in all modes
// - qualified edge raises interrupt normal/stop
// - restart edge sets flag, no interrupt
// - sleep edge wakes, enables regulator
// - pwm drives low-side, 0 off, 100 on
// - low-side overcurrent during on, flag, off
// - high-side diagnosis during on-time
// - switch shutdown rewrites selection to off
module fogc_fail_output_and_gpio_ctrl
#(
  parameter int PWM_W = fogc_pkg::PWM_W
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // operating mode and hardware config (1..4)
  input wire logic [2:0] opMode,
  input wire logic [2:0] hwConfig,
  // failure sources
  input wire logic wdTrigFail,
  input wire logic wdTrigOk,
  input wire logic wdDisabled,
  input wire logic thermalShutdownLevel2,
  input wire logic mainRegulatorShort,
  input wire logic mainRegulatorOv,
  input wire logic overvoltageResetEnable,
  // host controls
  input wire logic failureFlagClear,
  input wire logic failOutputTestBit,
  input wire logic pinSelWrite,
  input wire logic [2:0] pinSelData,
  input wire logic cfgLock,
  input wire logic pinWakePullSelectUp,
  input wire logic pinWakeEventClear,
  input wire logic [PWM_W-1:0] pwmDuty,
  input wire logic [PWM_W-1:0] pwmFrequencyReg,
  input wire logic ocClear,
  input wire logic olClear,
  // pin sensing
  input wire logic pinIn,
  input wire logic switchOverCurrent,
  input wire logic switchOpenLoad,
  // pin drive
  output logic pinLowOe,
  output logic pinHighOe,
  output logic pullUpEn,
  output logic pullDownEn,
  // status out
  output logic failureFlag,
  output logic watchdogFailureFlag,
  output logic failSafeReq,
  output logic [2:0] pinSel,
  output logic pinWakeEventFlag,
  output logic wakeLevelStatus,
  output logic pinOvercurrentFlag,
  output logic pinOpenLoadFlag,
  output logic interruptReq,
  output logic wakeReq
);
  typedef enum logic [3:0]
  {
    OUT_IDLE = 4'h1,
    OUT_FAIL = 4'h2,
    OUT_TEST = 4'h4,
    OUT_HOLD = 4'h8
  } fogc_out_e;
  typedef struct packed
  {
    fogc_out_e outState;
    logic [1:0] wdCount;
    logic failFlag;
    logic wdFlag;
    logic fsReq;
    logic [2:0] sel;
    logic wkFlag;
    logic lvl;
    logic oc;
    logic ol;
    logic lowOe;
    logic highOe;
    logic pu;
    logic pd;
    logic irq;
    logic wake;
    logic [2:0] prevMode;
  } fogc_s;
  fogc_s st, next_st;
  // helper wires
  logic wkEnable;
  logic filtLevel;
  logic edgeSeen;
  logic pwmOn;
  logic wdAssert;
  logic hardFail;
  logic anyFail;
  logic isFailRole;
  logic isNormal;
  logic enterRestart;
  logic enterFailSafe;
  logic enterSleep;
  logic switchOn;
  // ****************************************
  // sub-blocks
  // ****************************************
  fogc_wake_filter u_filter
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(wkEnable),
    .pinLevel(pinIn),
    .filtLevel(filtLevel),
    .edgeSeen(edgeSeen)
  );
  fogc_pwm #(.W(PWM_W)) u_pwm
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .duty(pwmDuty),
    .freqDiv(pwmFrequencyReg),
    .onPhase(pwmOn)
  );
  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    // wake capable as soon as selected
    wkEnable = (st.sel == fogc_pkg::SEL_WAKE);
    // codes 000..010 are the fail role
    isFailRole = (st.sel <= fogc_pkg::SEL_FAIL2);
    isNormal = (opMode == fogc_pkg::MODE_NORMAL);
    enterRestart = (opMode == fogc_pkg::MODE_RESTART) && (st.prevMode != fogc_pkg::MODE_RESTART);
    enterFailSafe = (opMode == fogc_pkg::MODE_FAILSAFE) && (st.prevMode != fogc_pkg::MODE_FAILSAFE);
    enterSleep = (opMode == fogc_pkg::MODE_SLEEP) && (st.prevMode != fogc_pkg::MODE_SLEEP);
    // configs 3 and 4 wait for a second failure
    wdAssert = wdTrigFail && ((hwConfig >= 3'h3) ? (st.wdCount != 2'h0) : 1'b1);
    // overvoltage only with reset enable
    hardFail = thermalShutdownLevel2 || mainRegulatorShort || (mainRegulatorOv && overvoltageResetEnable);
    // release needs overvoltage gone regardless of enable
    anyFail = thermalShutdownLevel2 || mainRegulatorShort || mainRegulatorOv;
    switchOn = pwmOn && (st.sel == fogc_pkg::SEL_LS || st.sel == fogc_pkg::SEL_HS);
  end
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.prevMode = opMode;
    next_st.irq = 1'b0;
    next_st.wake = 1'b0;
    next_st.fsReq = 1'b0;
    // watchdog failure count and flag
    if (wdTrigOk)
      next_st.wdFlag = 1'b0;
    if (enterSleep || (enterFailSafe && !st.wdFlag) || (opMode == fogc_pkg::MODE_STOP && wdDisabled))
      next_st.wdFlag = 1'b0;
    if (wdTrigFail)
    begin
      next_st.wdFlag = 1'b1;
      if (st.wdCount != 2'h3)
        next_st.wdCount = st.wdCount + 2'h1;
    end
    // failure flag, set wins over clear
    if (failureFlagClear)
      next_st.failFlag = 1'b0;
    if (wdAssert || hardFail)
    begin
      next_st.failFlag = 1'b1;
      // watchdog cause routes to fail-safe only from config 1/2
      next_st.fsReq = hardFail || hwConfig <= 3'h2;
    end
    // fail output state machine
    case (st.outState)
      OUT_IDLE:
      begin
        if (wdAssert || hardFail)
          next_st.outState = OUT_FAIL;
        else if (failOutputTestBit)
          next_st.outState = OUT_TEST;
      end
      OUT_FAIL:
      begin
        // held in every mode until released in Normal
        if (isNormal && !anyFail && !st.failFlag && !st.wdFlag && !failOutputTestBit)
          next_st.outState = OUT_IDLE;
      end
      OUT_TEST:
      begin
        if (wdAssert || hardFail)
          next_st.outState = OUT_FAIL;
        else if (enterRestart)
          next_st.outState = OUT_HOLD;
        else if (!failOutputTestBit)
          next_st.outState = OUT_IDLE;
      end
      OUT_HOLD:
      begin
        // stays off until test bit drops
        if (wdAssert || hardFail)
          next_st.outState = OUT_FAIL;
        else if (!failOutputTestBit)
          next_st.outState = OUT_IDLE;
      end
      default:
        next_st.outState = OUT_FAIL;
    endcase
    // pin selection, Normal only and not locked
    if (pinSelWrite && isNormal && !cfgLock)
      next_st.sel = pinSelData;
    // overcurrent / open load during on-time only
    if (ocClear)
      next_st.oc = 1'b0;
    if (olClear)
      next_st.ol = 1'b0;
    if (switchOn && switchOverCurrent)
    begin
      next_st.oc = 1'b1;
      next_st.sel = fogc_pkg::SEL_OFF;
    end
    if (pwmOn && st.sel == fogc_pkg::SEL_HS && switchOpenLoad)
      next_st.ol = 1'b1;
    if ((enterRestart || enterFailSafe) && (st.sel == fogc_pkg::SEL_LS || st.sel == fogc_pkg::SEL_HS))
      next_st.sel = fogc_pkg::SEL_OFF;
    // wake input events
    if (pinWakeEventClear || enterFailSafe)
      next_st.wkFlag = 1'b0;
    if (wkEnable && edgeSeen)
    begin
      next_st.wkFlag = 1'b1;
      if (opMode == fogc_pkg::MODE_NORMAL || opMode == fogc_pkg::MODE_STOP)
        next_st.irq = 1'b1;
      if (opMode == fogc_pkg::MODE_SLEEP)
        next_st.wake = 1'b1;
      // restart: flag only, no interrupt
    end
    // level status tracked in all modes
    if (wkEnable)
      next_st.lvl = filtLevel;
    else if (st.sel == fogc_pkg::SEL_LS || st.sel == fogc_pkg::SEL_HS)
      next_st.lvl = pinIn;
    else
      next_st.lvl = 1'b0;
    // pin drivers
    next_st.lowOe = (isFailRole && (next_st.outState == OUT_FAIL || next_st.outState == OUT_TEST))
      || (st.sel == fogc_pkg::SEL_LS && pwmOn && !(next_st.sel == fogc_pkg::SEL_OFF));
    next_st.highOe = st.sel == fogc_pkg::SEL_HS && pwmOn && !(next_st.sel == fogc_pkg::SEL_OFF);
    next_st.pu = wkEnable && pinWakePullSelectUp;
    next_st.pd = wkEnable && !pinWakePullSelectUp;
  end
  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      // power-up default is fail role
      st <= '0;
      st.outState <= OUT_IDLE;
      st.sel <= fogc_pkg::SEL_RESET;
    end
    else
      st <= next_st;
  end
  // ****************************************
  // outputs
  // ****************************************
  assign pinLowOe = st.lowOe;
  assign pinHighOe = st.highOe;
  assign pullUpEn = st.pu;
  assign pullDownEn = st.pd;
  assign failureFlag = st.failFlag;
  assign watchdogFailureFlag = st.wdFlag;
  assign failSafeReq = st.fsReq;
  assign pinSel = st.sel;
  assign pinWakeEventFlag = st.wkFlag;
  // readable in every mode, no mode gating
  assign wakeLevelStatus = st.lvl;
  assign pinOvercurrentFlag = st.oc;
  assign pinOpenLoadFlag = st.ol;
  assign interruptReq = st.irq;
  assign wakeReq = st.wake;
  // ****************************************
  // checks
  // ****************************************
  a_fail_asserts: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (thermalShutdownLevel2 && isFailRole && !pinSelWrite) |=> pinLowOe) else $error("thermal fail not driven");
  a_flag_on_fail: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hardFail |=> failureFlag && failSafeReq) else $error("flag missing");
  a_fail_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st.outState == OUT_FAIL && !isNormal) |=> st.outState == OUT_FAIL) else $error("fail released outside normal");
  a_release_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st.outState == OUT_FAIL && st.failFlag) |=> st.outState == OUT_FAIL) else $error("released with flag set");
  a_wd_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st.outState == OUT_FAIL && st.wdFlag) |=> st.outState == OUT_FAIL) else $error("released with watchdog flag");
  a_wd_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wdTrigFail && hwConfig <= 3'h2) |=> failureFlag) else $error("first watchdog failure missed");
  a_test_role: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st.sel == fogc_pkg::SEL_WAKE) |-> !pinLowOe) else $error("driven in wake role");
  a_lock_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgLock && !switchOn && !enterRestart && !enterFailSafe) |=> $stable(pinSel)) else $error("locked sel changed");
  a_restart_noirq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (opMode == fogc_pkg::MODE_RESTART) |=> !interruptReq) else $error("irq in restart");
  a_oc_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (switchOn && switchOverCurrent) |=> pinSel == fogc_pkg::SEL_OFF && pinOvercurrentFlag) else $error("oc no off");
endmodule
`default_nettype wire

// ===== sim/fogc_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external load and sensor on the shared pin
// ****************************************
module fogc_load_model
(
  // pin drive from the block
  input wire logic pinLowOe,
  input wire logic pinHighOe,
  input wire logic pullUpEn,
  input wire logic pullDownEn,
  // bench controls
  input wire logic extDrive,
  input wire logic extLevel,
  input wire logic ocInject,
  input wire logic olInject,
  // sensing back to the block
  output logic pinIn,
  output logic switchOverCurrent,
  output logic switchOpenLoad
);
  // wire level: switches win, then the outside source, then the pulls
  // an undriven pin without pull reads high, as the pull-up of the fail line would
  always_comb
  begin
    if (pinLowOe)
      pinIn = 1'b0;
    else if (pinHighOe)
      pinIn = 1'b1;
    else if (extDrive)
      pinIn = extLevel;
    else
      pinIn = ~pullDownEn | pullUpEn;
  end
  // faults only show while a switch is really on
  assign switchOverCurrent = ocInject & (pinLowOe | pinHighOe);
  assign switchOpenLoad = olInject & pinHighOe;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk = 1'b0, sys_rst = 1'b1;
  logic [2:0] opMode = 3'h0, hwConfig = 3'h1, pinSelData = 3'h0;
  logic wdTrigFail = 1'b0, wdTrigOk = 1'b0, wdDisabled = 1'b0, thermalShutdownLevel2 = 1'b0;
  logic mainRegulatorShort = 1'b0, mainRegulatorOv = 1'b0, overvoltageResetEnable = 1'b0;
  logic failureFlagClear = 1'b0, failOutputTestBit = 1'b0, pinSelWrite = 1'b0, cfgLock = 1'b0;
  logic pinWakePullSelectUp = 1'b0, pinWakeEventClear = 1'b0, ocClear = 1'b0, olClear = 1'b0;
  logic [7:0] pwmDuty = 8'h00, pwmFrequencyReg = 8'h01;
  logic extDrive = 1'b0, extLevel = 1'b0, ocInject = 1'b0, olInject = 1'b0;
  logic pinIn, switchOverCurrent, switchOpenLoad, pinLowOe, pinHighOe, pullUpEn, pullDownEn;
  logic failureFlag, watchdogFailureFlag, failSafeReq, pinWakeEventFlag, wakeLevelStatus;
  logic pinOvercurrentFlag, pinOpenLoadFlag, interruptReq, wakeReq;
  logic [2:0] pinSel;
  int errors = 0, nCompared = 0;
  // 20 mhz clock
  always #25 sys_clk = ~sys_clk;
  // ****************************************
  // block and far side
  // ****************************************
  fogc_fail_output_and_gpio_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .opMode(opMode),
    .hwConfig(hwConfig), .wdTrigFail(wdTrigFail), .wdTrigOk(wdTrigOk), .wdDisabled(wdDisabled),
    .thermalShutdownLevel2(thermalShutdownLevel2), .mainRegulatorShort(mainRegulatorShort),
    .mainRegulatorOv(mainRegulatorOv), .overvoltageResetEnable(overvoltageResetEnable),
    .failureFlagClear(failureFlagClear), .failOutputTestBit(failOutputTestBit),
    .pinSelWrite(pinSelWrite), .pinSelData(pinSelData), .cfgLock(cfgLock),
    .pinWakePullSelectUp(pinWakePullSelectUp), .pinWakeEventClear(pinWakeEventClear),
    .pwmDuty(pwmDuty), .pwmFrequencyReg(pwmFrequencyReg), .ocClear(ocClear), .olClear(olClear),
    .pinIn(pinIn), .switchOverCurrent(switchOverCurrent), .switchOpenLoad(switchOpenLoad),
    .pinLowOe(pinLowOe), .pinHighOe(pinHighOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
    .failureFlag(failureFlag), .watchdogFailureFlag(watchdogFailureFlag),
    .failSafeReq(failSafeReq), .pinSel(pinSel), .pinWakeEventFlag(pinWakeEventFlag),
    .wakeLevelStatus(wakeLevelStatus), .pinOvercurrentFlag(pinOvercurrentFlag),
    .pinOpenLoadFlag(pinOpenLoadFlag), .interruptReq(interruptReq), .wakeReq(wakeReq));
  fogc_load_model LOAD (.pinLowOe(pinLowOe), .pinHighOe(pinHighOe), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .extDrive(extDrive), .extLevel(extLevel), .ocInject(ocInject),
    .olInject(olInject), .pinIn(pinIn), .switchOverCurrent(switchOverCurrent),
    .switchOpenLoad(switchOpenLoad));
  // ****************************************
  // helpers
  // ****************************************
  // step n edges, then drive 5 ns later so nothing races the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // host clear of the failure flag, one cycle pulse
  task automatic clear_fail();
    failureFlagClear = 1'b1;
    tick(1);
    failureFlagClear = 1'b0;
    tick(2);
  endtask
  // selection write, one cycle pulse
  task automatic write_sel(input logic [2:0] code);
    pinSelData = code;
    pinSelWrite = 1'b1;
    tick(1);
    pinSelWrite = 1'b0;
    tick(2);
  endtask
  task automatic watchdog_failure_flag();
    wdTrigFail = 1'b1;
    tick(1);
    wdTrigFail = 1'b0;
    tick(2);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk(pinSel, fogc_pkg::SEL_RESET);
    chk(pinLowOe, 1'b0);
    $display("test reset done");
  endtask
  // config 3 asserts on second failure only, release needs trigger plus clear
  task automatic t_watchdog();
    hwConfig = 3'h3;
    watchdog_failure_flag();
    chk(pinLowOe, 1'b0);
    watchdog_failure_flag();
    chk({pinLowOe, failureFlag, watchdogFailureFlag}, 3'h7);
    hwConfig = 3'h1;
    clear_fail();
    chk(pinLowOe, 1'b1);
    wdTrigOk = 1'b1;
    tick(1);
    wdTrigOk = 1'b0;
    clear_fail();
    chk({pinLowOe, watchdogFailureFlag}, 2'h0);
    watchdog_failure_flag();
    chk(pinLowOe, 1'b1);
    opMode = fogc_pkg::MODE_SLEEP;
    tick(2);
    chk({pinLowOe, watchdogFailureFlag}, 2'h2);
    opMode = fogc_pkg::MODE_NORMAL;
    clear_fail();
    chk(pinLowOe, 1'b0);
    watchdog_failure_flag();
    opMode = fogc_pkg::MODE_STOP;
    wdDisabled = 1'b1;
    tick(2);
    chk({pinLowOe, watchdogFailureFlag}, 2'h2);
    opMode = fogc_pkg::MODE_NORMAL;
    wdDisabled = 1'b0;
    clear_fail();
    chk(pinLowOe, 1'b0);
    $display("test watchdog done");
  endtask
  // thermal, short and gated overvoltage, hold in stop, release in normal only
  task automatic t_sources();
    mainRegulatorOv = 1'b1;
    tick(2);
    chk(pinLowOe, 1'b0);
    overvoltageResetEnable = 1'b1;
    tick(1);
    chk({pinLowOe, failureFlag}, 2'h3);
    mainRegulatorOv = 1'b0;
    clear_fail();
    mainRegulatorShort = 1'b1;
    tick(1);
    chk(pinLowOe, 1'b1);
    mainRegulatorShort = 1'b0;
    clear_fail();
    thermalShutdownLevel2 = 1'b1;
    tick(1);
    chk({pinLowOe, failSafeReq}, 2'h3);
    thermalShutdownLevel2 = 1'b0;
    opMode = fogc_pkg::MODE_STOP;
    clear_fail();
    chk(pinLowOe, 1'b1);
    opMode = fogc_pkg::MODE_NORMAL;
    clear_fail();
    chk({pinLowOe, failureFlag}, 2'h0);
    $display("test sources done");
  endtask
  // test bit asserts, releases, dropped by restart, ignored off the fail role
  task automatic t_test_bit();
    failOutputTestBit = 1'b1;
    tick(2);
    chk(pinLowOe, 1'b1);
    failOutputTestBit = 1'b0;
    tick(2);
    chk(pinLowOe, 1'b0);
    failOutputTestBit = 1'b1;
    tick(2);
    opMode = fogc_pkg::MODE_RESTART;
    tick(2);
    chk(pinLowOe, 1'b0);
    opMode = fogc_pkg::MODE_NORMAL;
    tick(2);
    chk(pinLowOe, 1'b0);
    write_sel(fogc_pkg::SEL_OFF);
    chk({pinSel, pinLowOe}, 4'h8);
    failOutputTestBit = 1'b0;
    tick(2);
    failOutputTestBit = 1'b1;
    tick(2);
    chk(pinLowOe, 1'b0);
    failOutputTestBit = 1'b0;
    $display("test bit done");
  endtask
  // lock and mode gate the selection, then both switch roles
  task automatic t_switch();
    cfgLock = 1'b1;
    write_sel(fogc_pkg::SEL_LS);
    chk(pinSel, fogc_pkg::SEL_OFF);
    cfgLock = 1'b0;
    opMode = fogc_pkg::MODE_STOP;
    write_sel(fogc_pkg::SEL_LS);
    chk(pinSel, fogc_pkg::SEL_OFF);
    opMode = fogc_pkg::MODE_NORMAL;
    write_sel(fogc_pkg::SEL_LS);
    tick(4);
    chk({pinSel, pinLowOe}, {fogc_pkg::SEL_LS, 1'b0});
    pwmDuty = fogc_pkg::PWM_FULL;
    tick(600);
    chk({pinLowOe, wakeLevelStatus}, 2'h2);
    ocInject = 1'b1;
    tick(3);
    chk({pinOvercurrentFlag, pinLowOe, pinSel}, {2'h2, fogc_pkg::SEL_OFF});
    ocInject = 1'b0;
    ocClear = 1'b1;
    tick(1);
    ocClear = 1'b0;
    chk(pinOvercurrentFlag, 1'b0);
    write_sel(fogc_pkg::SEL_HS);
    tick(600);
    chk(pinHighOe, 1'b1);
    olInject = 1'b1;
    tick(3);
    chk(pinOpenLoadFlag, 1'b1);
    olInject = 1'b0;
    olClear = 1'b1;
    tick(1);
    olClear = 1'b0;
    chk(pinOpenLoadFlag, 1'b0);
    opMode = fogc_pkg::MODE_RESTART;
    tick(3);
    chk({pinHighOe, pinSel}, {1'b0, fogc_pkg::SEL_OFF});
    opMode = fogc_pkg::MODE_NORMAL;
    pwmDuty = 8'h00;
    $display("test switch done");
  endtask
  // bounded wait for a wake event, gathering the one-cycle pulses on the way
  task automatic wait_wake(output logic irqSeen, output logic wakeSeen);
    int k;
    irqSeen = 1'b0;
    wakeSeen = 1'b0;
    for (k = 0; k < 700 && pinWakeEventFlag !== 1'b1; k++)
    begin
      irqSeen = irqSeen | (interruptReq === 1'b1);
      wakeSeen = wakeSeen | (wakeReq === 1'b1);
      tick(1);
    end
    if (k == 700)
    begin
      errors++;
      finish_test();
    end
    irqSeen = irqSeen | (interruptReq === 1'b1);
    wakeSeen = wakeSeen | (wakeReq === 1'b1);
  endtask
  // host clear of the wake event flag, one cycle pulse
  task automatic clear_wake();
    pinWakeEventClear = 1'b1;
    tick(1);
    pinWakeEventClear = 1'b0;
  endtask
  // wake role: blanking, filter, flag and interrupt per mode, fail-safe clears flag
  task automatic t_wake();
    logic irqSeen, wakeSeen;
    pinWakePullSelectUp = 1'b1;
    extDrive = 1'b1;
    write_sel(fogc_pkg::SEL_WAKE);
    chk({pullUpEn, pullDownEn}, 2'h2);
    extLevel = 1'b1;
    tick(100);
    chk(pinWakeEventFlag, 1'b0);
    wait_wake(irqSeen, wakeSeen);
    chk({irqSeen, wakeSeen, wakeLevelStatus}, 3'h5);
    clear_wake();
    chk(pinWakeEventFlag, 1'b0);
    // falling edge while asleep wakes without interrupt
    opMode = fogc_pkg::MODE_SLEEP;
    extLevel = 1'b0;
    wait_wake(irqSeen, wakeSeen);
    chk({irqSeen, wakeSeen, wakeLevelStatus}, 3'h2);
    opMode = fogc_pkg::MODE_NORMAL;
    clear_wake();
    // rising edge in restart only sets the flag
    opMode = fogc_pkg::MODE_RESTART;
    extLevel = 1'b1;
    wait_wake(irqSeen, wakeSeen);
    chk({irqSeen, wakeSeen, pinWakeEventFlag}, 3'h1);
    opMode = fogc_pkg::MODE_FAILSAFE;
    tick(2);
    chk(pinWakeEventFlag, 1'b0);
    opMode = fogc_pkg::MODE_NORMAL;
    $display("test wake done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    tick(4);
    sys_rst = 1'b0;
    tick(1);
    t_reset();
    t_watchdog();
    t_sources();
    t_test_bit();
    t_switch();
    t_wake();
    finish_test();
  end
endmodule
`default_nettype wire
